/* File: rtl/epiu_pkg.sv */
// epiu_pkg: register map, field positions and reset values for the
// external pin interrupt unit.
// assumes byte-wide register port with eight-bit addresses.
package epiu_pkg;
	localparam logic [7:0] EPIU_ADDR_SENSE   = 8'h69;
	localparam logic [7:0] EPIU_ADDR_GMASK0  = 8'h6B;
	localparam logic [7:0] EPIU_ADDR_GMASK1  = 8'h6C;
	localparam logic [7:0] EPIU_ADDR_GMASK2  = 8'h6D;
	localparam logic [7:0] EPIU_ADDR_LMASK   = 8'h3D;
	localparam logic [7:0] EPIU_ADDR_LFLAGS  = 8'h3C;
	localparam logic [7:0] EPIU_ADDR_GCTRL   = 8'h68;
	localparam logic [7:0] EPIU_ADDR_GFLAGS  = 8'h3B;
	localparam logic [7:0] EPIU_ADDR_ACK     = 8'h3A;
	localparam logic [7:0] EPIU_RST_BYTE     = 8'h00;
	localparam int         EPIU_L1_SENSE_LSB = 2;
	localparam int         EPIU_L0_SENSE_LSB = 0;
	localparam int         EPIU_SENSE_BITS   = 4;
	localparam int         EPIU_LINE_BITS    = 2;
	localparam int         EPIU_GROUP_BITS   = 3;
	localparam int         EPIU_G1_BITS      = 7;
	localparam int         EPIU_SYNC_STAGES  = 2;
	// sense modes of a dedicated line
	typedef enum logic [1:0] {
		EPIU_SENSE_LOW  = 2'b00,
		EPIU_SENSE_ANY  = 2'b01,
		EPIU_SENSE_FALL = 2'b10,
		EPIU_SENSE_RISE = 2'b11
	} epiu_sense_t;
endpackage

/* File: rtl/epiu_top.sv */
// epiu_top: external line and pin-change interrupt detection with
// flags, masks and per-source requests to the core.
// assumes inputs synchronous to core_clk except where synchronised here;
// the core pulses the ack inputs when it enters a routine.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module epiu_top
	import epiu_pkg::*;
#(
	parameter int PC_LINES = 24
) (
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  external_line_zero,
	input  wire logic                  external_line_one,
	input  wire logic [PC_LINES-1:0]   pin_change_lines,
	input  wire logic                  processor_status_word_i,
	input  wire logic [1:0]            line_ack,
	input  wire logic [2:0]            group_ack,
	output logic                       line_zero_request,
	output logic                       line_one_request,
	output logic                       change_group_zero_request,
	output logic                       change_group_one_request,
	output logic                       change_group_two_request,
	output logic                       wake_request
);
	import epiu_pkg::*;

	initial begin
		if (PC_LINES != 24)
			$error("epiu_top serves exactly 24 pin-change lines");
	end

	logic [3:0]           sense_reg,  sense_next;
	logic [1:0]           lmask_reg,  lmask_next;
	logic [1:0]           lflag_reg,  lflag_next;
	logic [2:0]           gctrl_reg,  gctrl_next;
	logic [2:0]           gflag_reg,  gflag_next;
	logic [7:0]           gmask0_reg, gmask0_next;
	logic [6:0]           gmask1_reg, gmask1_next;
	logic [7:0]           gmask2_reg, gmask2_next;
	logic [7:0]           rdata_reg,  rdata_next;
	logic [1:0]           s1_reg,     s2_reg,  prev_reg;
	logic [PC_LINES-1:0]  p1_reg,     p2_reg,  pprev_reg;
	logic [1:0]           line_pin,   line_hit;
	logic [2:0]           grp_hit;
	logic [PC_LINES-1:0]  pc_en,      pc_tog;
	epiu_sense_t          mode [2];

	// both line pins share one synchroniser path
	assign line_pin = {external_line_one, external_line_zero};

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg    <= 2'h3;
			s2_reg    <= 2'h3;
			prev_reg  <= 2'h3;
			// pins idle high; ones avoid a false toggle after reset
			p1_reg    <= '1;
			p2_reg    <= '1;
			pprev_reg <= '1;
		end else begin
			s1_reg    <= line_pin;
			s2_reg    <= s1_reg;
			prev_reg  <= s2_reg;
			p1_reg    <= pin_change_lines;
			p2_reg    <= p1_reg;
			pprev_reg <= p2_reg;
		end
	end

	// pin direction is never looked at, so driven outputs still fire
	always_comb begin
		mode[0] = epiu_sense_t'(sense_reg[EPIU_L0_SENSE_LSB +: 2]);
		mode[1] = epiu_sense_t'(sense_reg[EPIU_L1_SENSE_LSB +: 2]);
		for (int i = 0; i < 2; i++) begin
			unique case (mode[i])
				EPIU_SENSE_LOW:  line_hit[i] = 1'b0;
				EPIU_SENSE_ANY:  line_hit[i] = s2_reg[i] ^ prev_reg[i];
				EPIU_SENSE_FALL: line_hit[i] = prev_reg[i] & ~s2_reg[i];
				EPIU_SENSE_RISE: line_hit[i] = ~prev_reg[i] & s2_reg[i];
			endcase
		end
	end

	// group masks pick the contributing lines
	assign pc_en  = {gmask2_reg, 1'b0, gmask1_reg, gmask0_reg};
	assign pc_tog = (p2_reg ^ pprev_reg) & pc_en;
	assign grp_hit = {|pc_tog[23:16], |pc_tog[14:8], |pc_tog[7:0]};

	always_comb begin
		sense_next  = sense_reg;
		lmask_next  = lmask_reg;
		gctrl_next  = gctrl_reg;
		gmask0_next = gmask0_reg;
		gmask1_next = gmask1_reg;
		gmask2_next = gmask2_reg;
		lflag_next  = lflag_reg & ~line_ack;
		gflag_next  = gflag_reg & ~group_ack;
		rdata_next  = EPIU_RST_BYTE;
		if (reg_wr) begin
			unique case (reg_addr)
				EPIU_ADDR_SENSE:  sense_next  = reg_wdata[3:0];
				EPIU_ADDR_LMASK:  lmask_next  = reg_wdata[1:0];
				EPIU_ADDR_GCTRL:  gctrl_next  = reg_wdata[2:0];
				EPIU_ADDR_GMASK0: gmask0_next = reg_wdata;
				EPIU_ADDR_GMASK1: gmask1_next = reg_wdata[6:0];
				EPIU_ADDR_GMASK2: gmask2_next = reg_wdata;
				// write one clears
				EPIU_ADDR_LFLAGS: lflag_next  = lflag_next & ~reg_wdata[1:0];
				EPIU_ADDR_GFLAGS: gflag_next  = gflag_next & ~reg_wdata[2:0];
				default: ;
			endcase
		end
		// set wins over any clear in the same cycle
		lflag_next = lflag_next | line_hit;
		gflag_next = gflag_next | grp_hit;
		// level mode keeps the flag at zero
		for (int i = 0; i < 2; i++)
			if (mode[i] == EPIU_SENSE_LOW)
				lflag_next[i] = 1'b0;
		if (reg_rd) begin
			// unused upper bits read as zero
			unique case (reg_addr)
				EPIU_ADDR_SENSE:  rdata_next = {4'h0, sense_reg};
				EPIU_ADDR_LMASK:  rdata_next = {6'h00, lmask_reg};
				EPIU_ADDR_LFLAGS: rdata_next = {6'h00, lflag_reg};
				EPIU_ADDR_GCTRL:  rdata_next = {5'h00, gctrl_reg};
				EPIU_ADDR_GFLAGS: rdata_next = {5'h00, gflag_reg};
				EPIU_ADDR_GMASK0: rdata_next = gmask0_reg;
				EPIU_ADDR_GMASK1: rdata_next = {1'b0, gmask1_reg};
				EPIU_ADDR_GMASK2: rdata_next = gmask2_reg;
				default:          rdata_next = EPIU_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sense_reg  <= '0;
			lmask_reg  <= '0;
			lflag_reg  <= '0;
			gctrl_reg  <= '0;
			gflag_reg  <= '0;
			gmask0_reg <= '0;
			gmask1_reg <= '0;
			gmask2_reg <= '0;
			rdata_reg  <= '0;
		end else begin
			sense_reg  <= sense_next;
			lmask_reg  <= lmask_next;
			lflag_reg  <= lflag_next;
			gctrl_reg  <= gctrl_next;
			gflag_reg  <= gflag_next;
			gmask0_reg <= gmask0_next;
			gmask1_reg <= gmask1_next;
			gmask2_reg <= gmask2_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// level requests follow the synchronised pin; a level that vanished
	// before start-up simply leaves no request behind
	logic [1:0] line_act;
	always_comb begin
		for (int i = 0; i < 2; i++)
			line_act[i] = (mode[i] == EPIU_SENSE_LOW) ? ~s2_reg[i]
			                                          : lflag_reg[i];
	end

	// each line has its own request, gated by mask and global enable
	assign line_zero_request = line_act[0] & lmask_reg[0]
	                           & processor_status_word_i;
	assign line_one_request  = line_act[1] & lmask_reg[1]
	                           & processor_status_word_i;
	assign change_group_zero_request = gflag_reg[0] & gctrl_reg[0]
	                                   & processor_status_word_i;
	assign change_group_one_request  = gflag_reg[1] & gctrl_reg[1]
	                                   & processor_status_word_i;
	assign change_group_two_request  = gflag_reg[2] & gctrl_reg[2]
	                                   & processor_status_word_i;

	// clockless wake path: raw pins against the held p2_reg for change pins, so it works with the clock
	// stopped; edge modes give no wake because edges need the clock
	logic wake_line;
	logic wake_pc;
	always_comb begin
		wake_line = 1'b0;
		for (int i = 0; i < 2; i++)
			if (mode[i] == EPIU_SENSE_LOW && lmask_reg[i] && !line_pin[i])
				wake_line = 1'b1;
	end
	assign wake_pc = |((pin_change_lines ^ p2_reg) & pc_en);
	assign wake_request = wake_line | wake_pc;

	AST_LINE0_FALL: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[0] == EPIU_SENSE_FALL && $fell(s2_reg[0]))
		|=> lflag_reg[0])
		else $error("line zero falling edge did not set flag");
	AST_LEVEL_FLAG: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[1] == EPIU_SENSE_LOW) |=> (lflag_reg[1] == 1'b0))
		else $error("line one flag set in level mode");
	AST_LINE_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
		line_zero_request |-> lmask_reg[0] && processor_status_word_i)
		else $error("line zero request without enables");
	AST_LEVEL_REQ: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[1] == EPIU_SENSE_LOW && lmask_reg[1] && processor_status_word_i
		 && !s2_reg[1]) |-> line_one_request)
		else $error("line one level request missing");
	AST_PIN_SYNC: assert property (@(posedge core_clk) disable iff (sys_rst)
		1'b1 |-> ##2 s2_reg == $past(line_pin, 2))
		else $error("synchroniser depth wrong");
	AST_GRP2_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gmask2_reg[0] && $changed(p2_reg[16])) |=> gflag_reg[2])
		else $error("group two flag not set on toggle");
	AST_GRP0_REQ: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gflag_reg[0] && gctrl_reg[0] && processor_status_word_i)
		|-> change_group_zero_request)
		else $error("group zero request missing");
	AST_W1C: assert property (@(posedge core_clk) disable iff (sys_rst)
		(reg_wr && reg_addr == EPIU_ADDR_GFLAGS && reg_wdata[1] && !grp_hit[1])
		|=> !gflag_reg[1])
		else $error("group one flag survived write one");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (sys_rst)
		$past(reg_rd && reg_addr == EPIU_ADDR_SENSE)
		|-> reg_rdata[7:4] == 4'h0)
		else $error("reserved control bits read nonzero");

	// rise and fall modes on line one, rise and any-change modes on line zero
	AST_LINE1_RISE: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[1] == EPIU_SENSE_RISE && $rose(s2_reg[1]))
		|=> lflag_reg[1])
		else $error("line one rising edge did not set flag");

	AST_LINE1_FALL: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[1] == EPIU_SENSE_FALL && $fell(s2_reg[1]))
		|=> lflag_reg[1])
		else $error("line one falling edge did not set flag");

	AST_LINE0_RISE: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[0] == EPIU_SENSE_RISE && $rose(s2_reg[0]))
		|=> lflag_reg[0])
		else $error("line zero rising edge did not set flag");

	AST_LINE0_ANY: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[0] == EPIU_SENSE_ANY && $changed(s2_reg[0]))
		|=> lflag_reg[0])
		else $error("line zero change did not set flag");

	AST_LINE_ACK: assert property (@(posedge core_clk) disable iff (sys_rst)
		(line_ack[0] && !line_hit[0])
		|=> !lflag_reg[0])
		else $error("line zero flag survived routine entry");

	AST_W1C_LINE: assert property (@(posedge core_clk) disable iff (sys_rst)
		(reg_wr && reg_addr == EPIU_ADDR_LFLAGS && reg_wdata[0]
		 && !line_hit[0]) |=> !lflag_reg[0])
		else $error("line zero flag survived write one");

	AST_LINE1_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
		line_one_request
		|-> lmask_reg[1] && processor_status_word_i)
		else $error("line one request without enables");

	AST_LEVEL_REQ0: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[0] == EPIU_SENSE_LOW && lmask_reg[0] && processor_status_word_i
		 && !s2_reg[0]) |-> line_zero_request)
		else $error("line zero level request missing");

	// wake must not wait for the clock
	AST_WAKE_LEVEL: assert property (@(posedge core_clk) disable iff (sys_rst)
		(mode[0] == EPIU_SENSE_LOW && lmask_reg[0] && !external_line_zero)
		|-> wake_request)
		else $error("low level gave no wake");

	AST_GRP0_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gmask0_reg[0] && $changed(p2_reg[0]))
		|=> gflag_reg[0])
		else $error("group zero flag not set on toggle");

	AST_GRP1_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gmask1_reg[0] && $changed(p2_reg[8]))
		|=> gflag_reg[1])
		else $error("group one flag not set on toggle");

	AST_GACK: assert property (@(posedge core_clk) disable iff (sys_rst)
		(group_ack[2] && !grp_hit[2])
		|=> !gflag_reg[2])
		else $error("group two flag survived routine entry");

	AST_GRP_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
		change_group_one_request
		|-> gctrl_reg[1] && processor_status_word_i)
		else $error("group one request without enables");

	AST_GRP2_REQ: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gflag_reg[2] && gctrl_reg[2] && processor_status_word_i)
		|-> change_group_two_request)
		else $error("group two request missing");

	AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		!$past(reg_rd)
		|-> reg_rdata == 8'h00)
		else $error("read data not zero outside read cycle");

	// main scenarios
	COV_WAKE: cover property (@(posedge core_clk) wake_request);
	COV_GRP2: cover property (@(posedge core_clk) change_group_two_request);
	COV_LINE_RISE: cover property (@(posedge core_clk)
		mode[0] == EPIU_SENSE_RISE ##1 lflag_reg[0]);
	COV_GRP1: cover property (@(posedge core_clk) change_group_one_request);
	COV_ACK: cover property (@(posedge core_clk)
		lflag_reg[1] && line_ack[1] ##1 !lflag_reg[1]);
endmodule

/* File: verification/epiu_pin_src.sv */
// epiu_pin_src: external sources on the dedicated and change pins.
// assumes the bench calls put_pins; pins idle high as with pull-ups.
`timescale 1ns/100ps
module epiu_pin_src (
	input  wire logic        core_clk,
	output logic             line_zero_pin,
	output logic             line_one_pin,
	output logic [23:0]      change_pins
);
	initial begin
		line_zero_pin = 1'b1;
		line_one_pin  = 1'b1;
		change_pins   = 24'hFFFFFF;
	end
	// level held 4 cycles: past the sampling and one instruction
	// low levels also outlast any start-up wait here
	task automatic put_pins(input logic l0, input logic l1,
			input logic [23:0] pc);
		@(posedge core_clk);
		line_zero_pin <= l0;
		line_one_pin  <= l1;
		change_pins   <= pc;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
endmodule

/* File: verification/testbench.sv */
// testbench: register and pin scenarios for the pin interrupt unit.
// assumes epiu_pkg and the pin source model are compiled first.
`timescale 1ns/100ps
module testbench;
	import epiu_pkg::*;
	logic        core_clk, sys_rst, reg_wr, reg_rd, psw;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [1:0]  line_ack;
	logic [2:0]  group_ack, greq;
	logic        l0, l1, lreq0, lreq1, wake;
	logic [23:0] pins, pcv;
	int          fails, check_count, cyc, m;
	logic [7:0]  ta [9] = '{EPIU_ADDR_SENSE, EPIU_ADDR_LMASK, EPIU_ADDR_GCTRL,
		EPIU_ADDR_GMASK0, EPIU_ADDR_GMASK1, EPIU_ADDR_GMASK2,
		EPIU_ADDR_LFLAGS, EPIU_ADDR_GFLAGS, 8'h00};
	logic [7:0]  te [9] = '{8'h0F, 8'h03, 8'h07, 8'hFF, 8'h7F, 8'hFF,
		8'h00, 8'h00, 8'h00};
	epiu_pin_src src (.core_clk(core_clk), .line_zero_pin(l0),
		.line_one_pin(l1), .change_pins(pins));
	epiu_top uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_line_zero(l0), .external_line_one(l1),
		.pin_change_lines(pins), .processor_status_word_i(psw),
		.line_ack(line_ack), .group_ack(group_ack),
		.line_zero_request(lreq0), .line_one_request(lreq1),
		.change_group_zero_request(greq[0]),
		.change_group_one_request(greq[1]),
		.change_group_two_request(greq[2]), .wake_request(wake));
	task automatic stop_test();
		if (fails == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// hang guard well above the few hundred cycles the tests use
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; psw = 1'b0;
		reg_addr = 8'h00; reg_wdata = 8'h00; line_ack = 2'b00;
		group_ack = 3'b000; cyc = 0; fails = 0; check_count = 0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (m = 0; m < 9; m++) r(ta[m], EPIU_RST_BYTE);
		for (m = 0; m < 9; m++) begin
			w(ta[m], 8'hFF);
			r(ta[m], te[m]);
		end
		psw <= 1'b1;
		w(EPIU_ADDR_LMASK, 8'h01);
		// modes any, fall, rise; each seen on a rise and on a fall
		for (m = 1; m < 4; m++) begin
			w(EPIU_ADDR_SENSE, m[7:0]);
			src.put_pins(1'b0, 1'b1, 24'hFFFFFF);
			w(EPIU_ADDR_LFLAGS, 8'h03);
			src.put_pins(1'b1, 1'b1, 24'hFFFFFF);
			chk({7'h00, lreq0}, {7'h00, m != 2});
			r(EPIU_ADDR_LFLAGS, {7'h00, m != 2});
			w(EPIU_ADDR_LFLAGS, 8'h01);
			#1;
			chk({7'h00, lreq0}, 8'h00);
			src.put_pins(1'b0, 1'b1, 24'hFFFFFF);
			r(EPIU_ADDR_LFLAGS, {7'h00, m != 3});
			w(EPIU_ADDR_LFLAGS, 8'h03);
		end
		src.put_pins(1'b1, 1'b1, 24'hFFFFFF);
		psw <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({7'h00, lreq0}, 8'h00);
		psw <= 1'b1;
		w(EPIU_ADDR_SENSE, 8'h00);
		src.put_pins(1'b0, 1'b1, 24'hFFFFFF);
		chk({7'h00, lreq0}, 8'h01);
		chk({7'h00, wake}, 8'h01);
		r(EPIU_ADDR_LFLAGS, 8'h00);
		src.put_pins(1'b1, 1'b1, 24'hFFFFFF);
		chk({7'h00, lreq0}, 8'h00);
		w(EPIU_ADDR_SENSE, 8'h0C);
		w(EPIU_ADDR_LMASK, 8'h02);
		src.put_pins(1'b1, 1'b0, 24'hFFFFFF);
		w(EPIU_ADDR_LFLAGS, 8'h03);
		src.put_pins(1'b1, 1'b1, 24'hFFFFFF);
		chk({7'h00, lreq1}, 8'h01);
		r(EPIU_ADDR_LFLAGS, 8'h02);
		@(posedge core_clk) line_ack <= 2'b10;
		@(posedge core_clk) line_ack <= 2'b00;
		r(EPIU_ADDR_LFLAGS, 8'h00);
		w(EPIU_ADDR_GCTRL, 8'h07);
		w(EPIU_ADDR_GMASK0, 8'h01);
		w(EPIU_ADDR_GMASK1, 8'h01);
		w(EPIU_ADDR_GMASK2, 8'h01);
		for (m = 0; m < 3; m++) begin
			pcv = 24'hFFFFFF ^ (24'h000001 << (8 * m));
			fork
				src.put_pins(1'b1, 1'b1, pcv);
				begin
					@(posedge core_clk);
					#1;
					chk({7'h00, wake}, 8'h01);
				end
			join
			chk({5'h00, greq}, 8'h01 << m);
			r(EPIU_ADDR_GFLAGS, 8'h01 << m);
			w(EPIU_ADDR_GFLAGS, 8'h07);
			src.put_pins(1'b1, 1'b1, 24'hFFFFFF);
			@(posedge core_clk) group_ack <= 3'b001 << m;
			@(posedge core_clk) group_ack <= 3'b000;
			r(EPIU_ADDR_GFLAGS, 8'h00);
		end
		src.put_pins(1'b1, 1'b1, 24'hFFFFFD);
		r(EPIU_ADDR_GFLAGS, 8'h00);
		stop_test();
	end
endmodule
